// *** hw/bit_ram.sv ***
`timescale 1ns/1ps
`default_nettype none

module bit_ram #(
  parameter int DEPTH  = 64,
  parameter int ADDR_W = 6
) (
  input  wire logic              clock,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              write_strobe,
  input  wire logic              write_data,
  output wire logic              read_data
);

  // power-up contents are defined so that early reads are never unknown
  logic cells [DEPTH] = '{default: 1'b0};

  // write on the clock, read combinationally like a small distributed ram
  always_ff @(posedge clock) begin
    if (write_strobe) begin
      cells[address] <= write_data;
    end
  end

  assign read_data = cells[address];

endmodule

`default_nettype wire

// *** hw/ram_based_shift_register.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "shift_delay_params.svh"

// Function
// - 64-deep one-bit ram circular buffer
// - advance pointer, read oldest, write new
// - bit reappears exactly 64 shifts later
// - four glitch-free half-period phase pulses
// - enable at edge triggers, registers, increments
// - request ignored right after a trigger
// - read data captured starting second phase
// - one full period settling before capture
// - input data stable until write strobe
// - write strobe registered from setup decode
// - address and data held through second phase
// - ram controls made from internal registers
module ram_based_shift_register #(
  parameter int DEPTH  = `SHIFT_DEPTH,
  parameter int ADDR_W = `SHIFT_ADDR_W
) (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic                          shift_enable,
  input  wire logic                          serial_in,
  output logic                               serial_out,
  output logic                               shift_busy,
  output var shift_delay_pkg::phase_pulses_s phases
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  shift_delay_pkg::seq_state_e state;
  logic [ADDR_W-1:0]           pointer;
  logic                        data_reg;
  logic                        ram_read;
  logic                        write_strobe;
  logic                        trigger;
  logic                        capture_edge;
  shift_delay_pkg::seq_state_e next_state;

  // clock runs at twice the shift rate; phases come from registers only
  // ----------------------------------------------------------------
  // trigger and sequencer
  // ----------------------------------------------------------------
  // trigger accepted on any edge except the one right after a trigger
  assign trigger = shift_enable && (state != shift_delay_pkg::seq_setup);

  // capture, strobe and busy share this one decode of the setup state
  assign capture_edge = (state == shift_delay_pkg::seq_setup) && !trigger;

  // sequence: trigger edge -> setup (one full period) -> capture edge
  always_comb begin
    next_state = state;
    if (trigger) begin
      next_state = shift_delay_pkg::seq_setup;
    end else begin
      case (state)
        shift_delay_pkg::seq_setup:  next_state = shift_delay_pkg::seq_second;
        shift_delay_pkg::seq_second: next_state = shift_delay_pkg::seq_idle;
        default:                     next_state = shift_delay_pkg::seq_idle;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= shift_delay_pkg::seq_idle;
    end else begin
      state <= next_state;
    end
  end

  // four half-period pulses modelled as registered phase flags each full period
  always_ff @(posedge clock) begin
    if (reset) begin
      phases <= '0;
    end else begin
      phases.first_phase_pulse  <= trigger;
      phases.second_phase_pulse <= phases.first_phase_pulse && !trigger;
      phases.third_phase_pulse  <= phases.second_phase_pulse && !trigger;
      phases.fourth_phase_pulse <= phases.third_phase_pulse && !trigger;
    end
  end

  // ----------------------------------------------------------------
  // pointer and input register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      pointer <= `SHIFT_PTR_RESET;
    end else if (trigger) begin
      if (pointer == `SHIFT_PTR_LAST) begin
        pointer <= `SHIFT_PTR_RESET;
      end else begin
        pointer <= pointer + `SHIFT_PTR_STEP;
      end
    end
  end

  // input bit held until the next trigger, which can land on the edge that ends the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      data_reg <= 1'b0;
    end else if (trigger) begin
      data_reg <= serial_in;
    end
  end

  // ----------------------------------------------------------------
  // ram and capture
  // ----------------------------------------------------------------
  // strobe registers the setup decode, so it lines up with the second phase, never gated by pins
  always_ff @(posedge clock) begin
    if (reset) begin
      write_strobe <= 1'b0;
    end else begin
      write_strobe <= capture_edge;
    end
  end

  bit_ram #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_ram (
    .clock        (clock),
    .address      (pointer),
    .write_strobe (write_strobe),
    .write_data   (data_reg),
    .read_data    (ram_read)
  );

  // old bit captured on the edge that opens the second phase, before write
  always_ff @(posedge clock) begin
    if (reset) begin
      serial_out <= 1'b0;
    end else if (capture_edge) begin
      serial_out <= ram_read;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      shift_busy <= 1'b0;
    end else begin
      shift_busy <= trigger || capture_edge;
    end
  end

  // ----------------------------------------------------------------
  // checks: helper state
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] ptr_at_setup;
  logic [1:0]        quiet_cycles;

  always_ff @(posedge clock) begin
    if (trigger) begin
      ptr_at_setup <= pointer + `SHIFT_PTR_STEP;
    end
  end

  // edges since the last accepted trigger, saturating
  always_ff @(posedge clock) begin
    if (reset || trigger) begin
      quiet_cycles <= 2'h0;
    end else if (quiet_cycles != `SHIFT_QUIET_MAX) begin
      quiet_cycles <= quiet_cycles + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // checks: sequencer and phases
  // ----------------------------------------------------------------
  no_double_a: assert property (@(posedge clock) disable iff (reset)
    trigger |=> !trigger)
    else $error("trigger accepted twice in a row");

  setup_follow_a: assert property (@(posedge clock) disable iff (reset)
    trigger |=> state == shift_delay_pkg::seq_setup)
    else $error("sequencer did not enter setup");

  state_legal_a: assert property (@(posedge clock) disable iff (reset)
    state == shift_delay_pkg::seq_idle || state == shift_delay_pkg::seq_setup
      || state == shift_delay_pkg::seq_second)
    else $error("sequencer in an unused state");

  idle_return_a: assert property (@(posedge clock) disable iff (reset)
    quiet_cycles >= `SHIFT_SETTLE |-> state == shift_delay_pkg::seq_idle)
    else $error("sequencer did not return to idle");

  phase_walk_a: assert property (@(posedge clock) disable iff (reset)
    phases.first_phase_pulse && !trigger |=> phases.second_phase_pulse)
    else $error("phase two did not follow phase one");

  phase_three_a: assert property (@(posedge clock) disable iff (reset)
    phases.second_phase_pulse && !trigger |=> phases.third_phase_pulse)
    else $error("phase three did not follow phase two");

  phase_four_a: assert property (@(posedge clock) disable iff (reset)
    phases.third_phase_pulse && !trigger |=> phases.fourth_phase_pulse)
    else $error("phase four did not follow phase three");

  phase_excl_a: assert property (@(posedge clock) disable iff (reset)
    $onehot0(phases))
    else $error("two phase pulses high at once");

  busy_start_a: assert property (@(posedge clock) disable iff (reset)
    trigger |=> shift_busy)
    else $error("busy not raised by trigger");

  busy_hold_a: assert property (@(posedge clock) disable iff (reset)
    trigger ##1 1'b1 |=> shift_busy)
    else $error("busy dropped in second cycle");

  reset_idle_a: assert property (@(posedge clock)
    reset |=> state == shift_delay_pkg::seq_idle && pointer == `SHIFT_PTR_RESET)
    else $error("reset did not clear sequencer");

  reset_quiet_a: assert property (@(posedge clock)
    reset |=> !write_strobe && !shift_busy && phases == '0)
    else $error("reset left a control high");

  // ----------------------------------------------------------------
  // checks: pointer and input register
  // ----------------------------------------------------------------
  ptr_step_a: assert property (@(posedge clock) disable iff (reset)
    trigger |=> pointer == ptr_at_setup)
    else $error("pointer did not advance by one");

  ptr_hold_a: assert property (@(posedge clock) disable iff (reset)
    !trigger |=> $stable(pointer))
    else $error("pointer moved without trigger");

  wrap_a: assert property (@(posedge clock) disable iff (reset)
    trigger && pointer == `SHIFT_PTR_LAST |=> pointer == `SHIFT_PTR_RESET)
    else $error("pointer did not wrap");

  data_take_a: assert property (@(posedge clock) disable iff (reset)
    trigger |=> data_reg == $past(serial_in))
    else $error("input bit not registered");

  data_keep_a: assert property (@(posedge clock) disable iff (reset)
    !trigger |=> $stable(data_reg))
    else $error("input register moved without trigger");

  // ----------------------------------------------------------------
  // checks: ram strobe and capture
  // ----------------------------------------------------------------
  data_hold_a: assert property (@(posedge clock) disable iff (reset)
    write_strobe |-> $stable(data_reg) && $stable(pointer))
    else $error("data or address moved at strobe");

  strobe_time_a: assert property (@(posedge clock) disable iff (reset)
    trigger ##1 !trigger |=> write_strobe)
    else $error("write strobe missing after trigger");

  strobe_single_a: assert property (@(posedge clock) disable iff (reset)
    write_strobe |=> !write_strobe)
    else $error("write strobe longer than one cycle");

  strobe_cause_a: assert property (@(posedge clock) disable iff (reset)
    write_strobe |-> $past(state) == shift_delay_pkg::seq_setup)
    else $error("strobe without sequencer");

  idle_quiet_a: assert property (@(posedge clock) disable iff (reset)
    state == shift_delay_pkg::seq_idle && !trigger |=> !write_strobe)
    else $error("strobe raised while idle");

  capture_a: assert property (@(posedge clock) disable iff (reset)
    trigger ##1 !trigger |=> serial_out == $past(ram_read))
    else $error("output not captured from ram");

  out_hold_a: assert property (@(posedge clock) disable iff (reset)
    !capture_edge |=> $stable(serial_out))
    else $error("output changed outside capture");

  // ----------------------------------------------------------------
  // main scenarios
  // ----------------------------------------------------------------
  shift_c: cover property (@(posedge clock) disable iff (reset)
    trigger ##1 !trigger ##1 write_strobe);

  b2b_c: cover property (@(posedge clock) disable iff (reset)
    trigger ##2 trigger);

  wrap_c: cover property (@(posedge clock) disable iff (reset)
    trigger && pointer == `SHIFT_PTR_LAST);

  idle_gap_c: cover property (@(posedge clock) disable iff (reset)
    quiet_cycles == `SHIFT_QUIET_MAX ##1 trigger);

  reset_mid_c: cover property (@(posedge clock)
    !reset ##1 reset);

endmodule

`default_nettype wire

// *** hw/shift_delay_params.svh ***
`ifndef SHIFT_DELAY_PARAMS_SVH
`define SHIFT_DELAY_PARAMS_SVH

`define SHIFT_DEPTH      64
`define SHIFT_ADDR_W     6
`define SHIFT_PTR_RESET  6'h00
`define SHIFT_PTR_STEP   6'h01
`define SHIFT_PTR_LAST   6'h3f
`define SHIFT_QUIET_MAX  2'h3
`define SHIFT_SETTLE     2'h2

`endif

// *** hw/shift_delay_pkg.sv ***
package shift_delay_pkg;

  typedef enum logic [2:0] {
    seq_idle  = 3'b000,
    seq_setup = 3'b001,
    seq_first  = 3'b010,
    seq_second = 3'b011,
    seq_third  = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic first_phase_pulse;
    logic second_phase_pulse;
    logic third_phase_pulse;
    logic fourth_phase_pulse;
  } phase_pulses_s;

endpackage

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// delay line bench
// ----------------------------------------
module tb;
  logic                           clock      = 1'b0;
  logic                           reset      = 1'b1;
  logic                           prev_reset = 1'b0;
  logic [1:0]                     mode       = 2'h0;
  logic                           shift_enable;
  logic                           serial_in;
  logic                           serial_out;
  logic                           shift_busy;
  shift_delay_pkg::phase_pulses_s phases;
  int                             n_errors   = 0;
  int                             num_checks = 0;
  int                             cycles     = 0;
  logic                           acc;
  logic                           acc1       = 1'b0;
  logic                           acc2       = 1'b0;
  logic                           acc3       = 1'b0;
  logic                           acc4       = 1'b0;
  logic [1:0]                     pipe [3]   = '{2'h0, 2'h0, 2'h0};
  logic                           hist [$];

  always #25 clock = ~clock;

  user_source i_src (
    .clock        (clock),
    .mode         (mode),
    .shift_enable (shift_enable),
    .serial_in    (serial_in)
  );

  ram_based_shift_register i_dut (
    .clock        (clock),
    .reset        (reset),
    .shift_enable (shift_enable),
    .serial_in    (serial_in),
    .serial_out   (serial_out),
    .shift_busy   (shift_busy),
    .phases       (phases)
  );

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // bit due out once 64 later shifts have been taken
  function automatic logic [1:0] next_expect(input logic bit_in);
    hist.push_back(bit_in);
    if (hist.size() > 64) begin
      return {1'b1, hist.pop_front()};
    end
    return 2'h0;
  endfunction

  // one-cycle phase pulses; a newer trigger cuts the tail of an older walk
  function automatic logic [3:0] phase_expect(input logic a1, input logic a2,
                                              input logic a3, input logic a4);
    return {a1, a2 && !a1, a3 && !a2 && !a1, a4 && !a3 && !a2 && !a1};
  endfunction

  // reference of acceptance and delay, sampled at each edge
  always @(posedge clock) begin
    cycles++;
    if (reset) begin
      if (prev_reset) begin
        check({1'b0, serial_out, shift_busy, |phases}, 4'h0);
      end
      hist.delete();
      pipe = '{2'h0, 2'h0, 2'h0};
      acc1 = 1'b0;
      acc2 = 1'b0;
      acc3 = 1'b0;
      acc4 = 1'b0;
    end else begin
      if (pipe[2][1]) begin
        check(serial_out, pipe[2][0]);
      end
      check(phases.first_phase_pulse, acc1);
      check(shift_busy, acc1 | acc2);
      check(phases, phase_expect(acc1, acc2, acc3, acc4));
      acc = shift_enable && !acc1;
      pipe[2] = pipe[1];
      pipe[1] = pipe[0];
      pipe[0] = acc ? next_expect(serial_in) : 2'h0;
      acc4 = acc3;
      acc3 = acc2;
      acc2 = acc1;
      acc1 = acc;
    end
    prev_reset = reset;
    if (cycles > 3000) begin
      n_errors++;
      complete_run();
    end
  end

  // back-to-back requests, random ones, reset mid-run, idle
  initial begin
    void'($urandom(32'h6088));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    mode  <= 2'h1;
    repeat (300) @(posedge clock);
    mode  <= 2'h2;
    repeat (600) @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (500) @(posedge clock);
    mode  <= 2'h0;
    repeat (10) @(posedge clock);
    complete_run();
  end
endmodule

`default_nettype wire

// *** testbench/user_source.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// requester beside the delay line
// ----------------------------------------
module user_source (
  input  wire logic       clock,
  input  wire logic [1:0] mode,
  output var  logic       shift_enable,
  output var  logic       serial_in
);
  // mode 0 idle, 1 request on every edge, 2 random requests
  initial begin
    shift_enable = 1'b0;
    serial_in    = 1'b0;
  end

  // request held across the sampling edge, new bit every cycle
  always @(posedge clock) begin
    shift_enable <= (mode == 2'h1) || ((mode == 2'h2) && ($urandom % 3 != 0));
    serial_in    <= 1'($urandom);
  end
endmodule

`default_nettype wire
